// >>> verilog/rdc_top.sv
// Reset level generation and sequential rail discharge controller
`timescale 1ns/1ps

// Contract
// R01: Reset pad is active high; a one requests hardware reset.
// R02: Power-on reset releases only with core, battery and brownout all good.
// R03: Power-on reset clears every register of the chip; code leaves bod_stat and the discharge sequencer as they are.
// R04: Hardware reset from pad, watchdog, power-on reset or debugger reboot write.
// R05: Software reset is asserted whenever hardware reset is active.
// R06: Software reset is OR of CPU request and soft reboot bit.
// R07: Reboot-after-sleep bit makes waking from sleep issue hardware reset.
// R08: Discharge config and status registers cleared only by power-on reset; code clears only the config on it.
// R09: Control registers cleared by hardware reset, kept through software reset.
// R10: Remaining registers cleared by software, hardware and power-on reset; code clears only the read path on them.
// R11: Pad assertion discharges each rail enabled in the discharge config.
// R12: Discharge config is write-one; firmware loads it from the OTP field.
// R13: Each rail discharge transistor stays on for one millisecond.
// R14: Enabled rails discharge one after another, never together.
// R15: Regulators held off until discharge ends, then one millisecond settle.
// R16: External source holds the pad at least 4 ms for full discharge.
// R17: Software trigger register bits also start rail discharge.
// R18: Enabled rail brownout on any of five rails issues power-on reset.
// R19: Battery below low threshold raises interrupt, not a reset.
// R20: Core rail has three thresholds; below floor always forces power-on reset.
// R21: Brownout escalates to reset only when brownout reboot enable is set.
// R22: Pad is synchronised; rails go in fixed order, disabled ones skipped.
// R23: Hardware reset stays asserted until a pad-started sequence has finished.
module rdc_top
    import rdc_pkg::*;
#(
    parameter int DIS_CYCLES = DISCHARGE_CYCLES,
    parameter int SET_CYCLES = SETTLE_CYCLES
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic reset_pad,
    input wire logic core_rail_ok,
    input wire logic battery_rail_ok,
    input wire logic core_below_floor,
    input wire logic battery_low,
    input wire logic [4:0] rail_low,
    input wire logic watchdog_expired,
    input wire logic cpu_reset_request,
    input wire logic wake_from_sleep,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic por_reset,
    output logic hw_reset,
    output logic soft_reboot_bit,
    output logic [2:0] discharge_on,
    output logic [2:0] regulator_hold_off,
    output logic [1:0] core_threshold_sel,
    output logic dcdc_irq
);
    localparam int PIN_W = 10;
    localparam logic [TIMER_W-1:0] DIS_LOAD = TIMER_W'(DIS_CYCLES - 1);
    localparam logic [TIMER_W-1:0] SET_LOAD = TIMER_W'(SET_CYCLES - 1);

    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic pad_prev;
        logic por;
        logic hw;
        logic sw;
        logic [2:0] cfg;
        logic soft_reboot;
        logic wake_reboot;
        logic [4:0] bod_en;
        logic bod_reboot;
        logic [1:0] core_thr;
        logic [4:0] bod_stat;
        rdc_state_t state;
        logic [2:0] mask;
        logic [TIMER_W-1:0] timer;
        logic pad_seq;
        logic irq;
        logic [31:0] rdata;
    } rdc_regs_t;

    rdc_regs_t q, d;

    // Synchronised pin view, second stage only
    logic pad_s, core_ok_s, bat_ok_s, floor_s, bat_low_s;
    logic [4:0] rail_low_s;
    assign pad_s = q.s2[0]; // R01 R22
    assign core_ok_s = q.s2[1];
    assign bat_ok_s = q.s2[2];
    assign floor_s = q.s2[3];
    assign bat_low_s = q.s2[4];
    assign rail_low_s = q.s2[9:5];

    // Reset sources
    logic bod_trip, por_req, dbg_wr, hw_req, sw_req, pad_rise, sw_trig, busy;
    assign bod_trip = (|(rail_low_s & q.bod_en)) & q.bod_reboot; // R18 R21
    assign por_req = ~core_ok_s | ~bat_ok_s | floor_s | bod_trip; // R02 R20
    assign dbg_wr = wr && addr == RDC_DBG_REBOOT_OFS && wdata == RDC_DBG_KEY;
    assign busy = q.state != RDC_IDLE;
    assign hw_req = pad_s | watchdog_expired | q.por | dbg_wr // R04
        | (wake_from_sleep & q.wake_reboot) // R07
        | (busy & q.pad_seq); // R23
    assign sw_req = q.hw | cpu_reset_request | q.soft_reboot; // R05 R06
    assign pad_rise = pad_s & ~q.pad_prev;
    assign sw_trig = wr && addr == RDC_DIS_TRIG_OFS && wdata[2:0] != 3'h0; // R17

    // First enabled rail at or above a position, fixed order
    function automatic rdc_state_t next_rail(input logic [2:0] m, input int from);
        rdc_state_t s;
        s = RDC_SETTLE;
        if (from <= RDC_R18P && m[RDC_R18P])
            s = RDC_DIS18P;
        if (from <= RDC_R18 && m[RDC_R18])
            s = RDC_DIS18;
        if (from <= RDC_R14 && m[RDC_R14])
            s = RDC_DIS14;
        return s;
    endfunction

    // Next state of every register
    always_comb
    begin
        d = q;
        d.rdata = 32'h0000_0000;
        d.s1 = {rail_low, battery_low, core_below_floor, battery_rail_ok,
                core_rail_ok, reset_pad};
        d.s2 = q.s1;
        d.pad_prev = pad_s;
        d.por = por_req;
        d.hw = hw_req;
        d.sw = sw_req;
        d.irq = bat_low_s; // R19
        d.soft_reboot = 1'b0;

        // Register writes
        if (wr)
        begin
            if (addr == RDC_DIS_CFG_OFS)
                d.cfg = q.cfg | wdata[2:0]; // R12
            else if (addr == RDC_SYS_CTRL_OFS)
                d.soft_reboot = wdata[RDC_SOFT_REBOOT_BIT]; // R06
            else if (addr == RDC_PWR_CTRL_OFS)
                d.wake_reboot = wdata[RDC_WAKE_REBOOT_BIT];
            else if (addr == RDC_BOD_CTRL2_OFS)
            begin
                d.bod_en = wdata[RDC_BOD_EN_LSB +: RDC_BOD_RAILS];
                d.bod_reboot = wdata[RDC_BOD_REBOOT_BIT];
                d.core_thr = wdata[RDC_CORE_THR_LSB +: 2]; // R20
            end
            else if (addr == RDC_BOD_STAT_OFS)
                d.bod_stat = q.bod_stat & ~wdata[4:0];
        end
        // Trip capture; set wins over the clear above
        d.bod_stat = d.bod_stat | (rail_low_s & q.bod_en);

        // Register reads, data in the next cycle
        if (rd)
        begin
            if (addr == RDC_DIS_CFG_OFS)
                d.rdata = {29'h0, q.cfg};
            else if (addr == RDC_SYS_CTRL_OFS)
                d.rdata = {31'h0, q.soft_reboot};
            else if (addr == RDC_PWR_CTRL_OFS)
                d.rdata = {31'h0, q.wake_reboot};
            else if (addr == RDC_BOD_CTRL2_OFS)
                d.rdata = {22'h0, q.core_thr, 2'h0, q.bod_reboot, q.bod_en};
            else if (addr == RDC_STATUS_OFS)
                d.rdata = {16'h0, 3'h0, q.state, q.pad_seq, q.mask,
                           q.irq, q.sw, q.hw, q.por};
            else if (addr == RDC_BOD_STAT_OFS)
                d.rdata = {27'h0, q.bod_stat};
            else
                d.rdata = 32'h0000_0000;
        end

        // Discharge sequencer
        case (q.state)
            RDC_IDLE:
            begin
                d.pad_seq = 1'b0;
                if (pad_rise && q.cfg != 3'h0)
                begin
                    d.mask = q.cfg; // R11
                    d.pad_seq = 1'b1;
                    d.state = next_rail(q.cfg, RDC_R14); // R22
                    d.timer = DIS_LOAD;
                end
                else if (sw_trig)
                begin
                    d.mask = wdata[2:0]; // R17
                    d.state = next_rail(wdata[2:0], RDC_R14);
                    d.timer = DIS_LOAD;
                end
            end
            RDC_DIS14, RDC_DIS18, RDC_DIS18P:
            begin
                d.pad_seq = q.pad_seq | pad_rise;
                if (q.timer != '0)
                    d.timer = q.timer - 1'b1; // R13
                else
                begin
                    // One rail at a time, next enabled rail only
                    if (q.state == RDC_DIS14)
                        d.state = next_rail(q.mask, RDC_R18); // R14
                    else if (q.state == RDC_DIS18)
                        d.state = next_rail(q.mask, RDC_R18P); // R14
                    else
                        d.state = RDC_SETTLE;
                    d.timer = (d.state == RDC_SETTLE) ? SET_LOAD : DIS_LOAD;
                end
            end
            RDC_SETTLE:
            begin
                d.pad_seq = q.pad_seq | pad_rise;
                if (q.timer != '0)
                    d.timer = q.timer - 1'b1; // R15
                else
                begin
                    d.state = RDC_IDLE;
                    d.mask = 3'h0;
                end
            end
            default:
            begin
                d.state = RDC_IDLE;
                d.mask = 3'h0;
            end
        endcase

        // Power-on reset clears the configuration kept through other resets
        if (q.por)
        begin
            d.cfg = 3'h0; // R08 R03
        end
        // Hardware reset clears the control group
        if (q.hw)
        begin
            d.soft_reboot = 1'b0; // R09
            d.wake_reboot = 1'b0;
            d.bod_en = RDC_BOD_EN_RST;
            d.bod_reboot = RDC_BOD_REBOOT_RST;
            d.core_thr = RDC_CORE_THR_RST;
        end
        // Software reset clears the rest; here only the read path
        if (q.sw)
            d.rdata = 32'h0000_0000; // R10
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            // Sync stages start as rails bad, pad low: POR cannot slip out early
            q <= '0;
            q.por <= 1'b1;
            q.hw <= 1'b1;
            q.sw <= 1'b1;
            q.bod_en <= RDC_BOD_EN_RST;
            q.bod_reboot <= RDC_BOD_REBOOT_RST;
            q.core_thr <= RDC_CORE_THR_RST;
            q.state <= RDC_IDLE;
        end
        else if (clk_en)
            q <= d;
    end

    // Outputs from flip-flops; discharge_on and regulator_hold_off decoded from state and mask
    assign rdata = q.rdata;
    assign por_reset = q.por; // R03
    assign hw_reset = q.hw;
    assign soft_reboot_bit = q.sw;
    assign dcdc_irq = q.irq;
    assign core_threshold_sel = q.core_thr;
    assign discharge_on = {q.state == RDC_DIS18P, q.state == RDC_DIS18,
                           q.state == RDC_DIS14};
    // Hold off each masked rail until the last discharge slot is over
    assign regulator_hold_off = (busy && q.state != RDC_SETTLE) ? q.mask : 3'h0; // R15

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    onehot_dis_a: assert property ($onehot0(discharge_on)) // R14
        else $error("two rails discharging at once");
    sw_follows_hw_a: assert property (clk_en && q.hw |=> soft_reboot_bit) // R05
        else $error("software reset missing during hardware reset");
    hw_from_por_a: assert property (clk_en && q.por |=> hw_reset) // R04
        else $error("power-on reset did not raise hardware reset");
    cpu_req_sw_a: assert property (clk_en && cpu_reset_request |=> soft_reboot_bit) // R06
        else $error("cpu request did not raise software reset");
    floor_por_a: assert property (clk_en && floor_s |=> por_reset) // R20
        else $error("core floor did not force power-on reset");
    good_release_a: assert property (clk_en && !q.por |-> // R02
        $past(core_ok_s) && $past(bat_ok_s) && !$past(floor_s))
        else $error("power-on reset released with a rail low");
    hold_busy_a: assert property (q.pad_seq && q.state != RDC_IDLE && clk_en
        |=> hw_reset) // R23
        else $error("hardware reset dropped during pad sequence");
    cfg_wone_a: assert property (clk_en && !q.por |=> (q.cfg & $past(q.cfg)) == $past(q.cfg)) // R12
        else $error("discharge config bit cleared without power-on reset");
    skip_rail_a: assert property (q.state == RDC_DIS18 |-> q.mask[RDC_R18]) // R22
        else $error("disabled rail given a slot");
    hold_off_a: assert property (discharge_on != 3'h0 |-> (regulator_hold_off & q.mask) == q.mask) // R15
        else $error("regulator released during discharge");
    irq_no_por_a: assert property (clk_en && bat_low_s && core_ok_s && bat_ok_s
        && !floor_s && !bod_trip |=> dcdc_irq && !por_reset) // R19
        else $error("battery low handled as reset");

    // Reset sources reach their levels one edge later
    pad_hw_a: assert property (clk_en && pad_s |=> hw_reset) // R01
        else $error("reset pad did not raise hardware reset");
    dbg_hw_a: assert property (clk_en && dbg_wr |=> hw_reset) // R04
        else $error("debugger reboot write did not raise hardware reset");
    wake_hw_a: assert property (clk_en && wake_from_sleep // R07
        && q.wake_reboot |=> hw_reset)
        else $error("wake with reboot bit did not raise hardware reset");
    bat_por_a: assert property (clk_en && !bat_ok_s |=> por_reset) // R02
        else $error("battery rail low did not hold power-on reset");
    bod_mask_a: assert property (clk_en && !q.bod_reboot && core_ok_s // R21
        && bat_ok_s && !floor_s |=> !por_reset)
        else $error("brownout escalated with reboot enable clear");

    // Reset groups and sequencer slots
    por_cfg_a: assert property (clk_en && q.por |=> q.cfg == 3'h0) // R08
        else $error("power-on reset left discharge config set");
    hw_ctrl_a: assert property (clk_en && q.hw // R09
        |=> core_threshold_sel == RDC_CORE_THR_RST && !q.wake_reboot)
        else $error("hardware reset left control group set");
    slot_len_a: assert property (clk_en && discharge_on != 3'h0 && q.timer != '0 // R13
        |=> $stable(discharge_on))
        else $error("discharge slot ended early");
    skip_slot_a: assert property (clk_en && q.state == RDC_DIS14 && q.timer == '0 // R22
        && !q.mask[RDC_R18] && q.mask[RDC_R18P] |=> discharge_on == 3'h4)
        else $error("disabled rail not skipped");
    pad_start_a: assert property (clk_en && !busy && pad_rise && q.cfg != 3'h0 // R11
        |=> discharge_on != 3'h0 && q.pad_seq)
        else $error("pad edge did not start discharge");
    sw_start_a: assert property (clk_en && !busy && sw_trig // R17
        && !(pad_rise && q.cfg != 3'h0) |=> discharge_on != 3'h0 && !q.pad_seq)
        else $error("software trigger did not start discharge");

    pad_seq_c: cover property (q.pad_seq && q.state == RDC_SETTLE);
    sw_seq_c: cover property (!q.pad_seq && q.state == RDC_DIS18P);
    skip_c: cover property (q.state == RDC_DIS14 ##[1:1000] q.state == RDC_DIS18P);
    bod_c: cover property (bod_trip ##2 por_reset);
endmodule

// >>> verilog/rdc_pkg.sv
// Constants shared by the reset and rail discharge controller
package rdc_pkg;
    // Clock rate and sequencer timing
    localparam int CLK_MHZ = 100;
    localparam int DISCHARGE_TIME_US = 1000;
    localparam int SETTLE_TIME_US = 1000;
    localparam int DISCHARGE_CYCLES = DISCHARGE_TIME_US * CLK_MHZ;
    localparam int SETTLE_CYCLES = SETTLE_TIME_US * CLK_MHZ;
    localparam int TIMER_W = 17;

    // Register indexes are byte offsets on the plain port
    localparam logic [7:0] RDC_DIS_CFG_OFS = 8'h00;
    localparam logic [7:0] RDC_DIS_TRIG_OFS = 8'h04;
    localparam logic [7:0] RDC_SYS_CTRL_OFS = 8'h08;
    localparam logic [7:0] RDC_PWR_CTRL_OFS = 8'h0C;
    localparam logic [7:0] RDC_BOD_CTRL2_OFS = 8'h10;
    localparam logic [7:0] RDC_DBG_REBOOT_OFS = 8'h14;
    localparam logic [7:0] RDC_STATUS_OFS = 8'h18;
    localparam logic [7:0] RDC_BOD_STAT_OFS = 8'h1C;

    // Field positions
    localparam int RDC_SOFT_REBOOT_BIT = 0;
    localparam int RDC_WAKE_REBOOT_BIT = 0;
    localparam int RDC_BOD_EN_LSB = 0;
    localparam int RDC_BOD_REBOOT_BIT = 5;
    localparam int RDC_CORE_THR_LSB = 8;
    localparam int RDC_RAILS = 3;
    localparam int RDC_BOD_RAILS = 5;

    // Rail index in discharge order: one_four, one_eight, one_eight_periph
    localparam int RDC_R14 = 0;
    localparam int RDC_R18 = 1;
    localparam int RDC_R18P = 2;

    // Reset values
    localparam logic [4:0] RDC_BOD_EN_RST = 5'h08;
    localparam logic RDC_BOD_REBOOT_RST = 1'b1;
    localparam logic [1:0] RDC_CORE_THR_RST = 2'h2;

    // Debugger reboot key; value is arbitrary
    localparam logic [31:0] RDC_DBG_KEY = 32'h0000A5A5;

    // Discharge sequencer states
    typedef enum logic [4:0] {
        RDC_IDLE = 5'b00001,
        RDC_DIS14 = 5'b00010,
        RDC_DIS18 = 5'b00100,
        RDC_DIS18P = 5'b01000,
        RDC_SETTLE = 5'b10000
    } rdc_state_t;
endpackage

// >>> verification/rdc_pad_source.sv
// External reset source model driving the active-high reset pad
`timescale 1ns/1ps
module rdc_pad_source
#(
    parameter int HOLD = 90
)(
    input wire logic clk,
    input wire logic start,
    input wire logic short_hold,
    output logic reset_pad
);
    int cnt = 0;

    // Pad held long enough for every rail plus settle; short only when the bench asks
    always @(posedge clk)
    begin
        if (start)
            cnt <= short_hold ? 5 : HOLD;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end

    // Pull-down on the pad, so released means low
    assign reset_pad = (cnt > 0);
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the reset and rail discharge controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench;
    import rdc_pkg::*;
    localparam int N = 20;
    typedef struct {logic [31:0] pre; logic [2:0] src; logic [7:0] a; logic [31:0] d;
        logic hw; logic sw;} rdc_row_t;
    logic clk = 0, rst = 1, pad_go = 0, pad_short = 0, core_ok = 0, floor = 0, bat_low = 0;
    logic wd = 0, cpu = 0, wake = 0, wr = 0, rd = 0, bat_ok = 1, reset_pad, sp, sh, ss;
    logic por_reset, hw_reset, soft_reboot_bit, dcdc_irq;
    logic [4:0] rail_low = 5'h00;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [2:0] dis_on, hold_off, ho;
    logic [1:0] thr_sel;
    int num_errors = 0, tests_run = 0, n;
    // Source rows: power control preset, {watchdog, cpu, wake}, write, expected levels
    rdc_row_t rows[7] = '{
        '{32'h0, 3'h4, 8'hFF, 32'h0, 1'h1, 1'h1}, '{32'h0, 3'h2, 8'hFF, 32'h0, 1'h0, 1'h1},
        '{32'h0, 3'h0, 8'h08, 32'h1, 1'h0, 1'h1}, '{32'h0, 3'h0, 8'h14, RDC_DBG_KEY, 1'h1, 1'h1},
        '{32'h0, 3'h0, 8'h14, 32'h1234, 1'h0, 1'h0}, '{32'h1, 3'h1, 8'hFF, 32'h0, 1'h1, 1'h1},
        '{32'h0, 3'h1, 8'hFF, 32'h0, 1'h0, 1'h0}};

    rdc_top #(.DIS_CYCLES(N), .SET_CYCLES(N)) DUT (.clk(clk), .rst(rst), .clk_en(1'h1),
        .reset_pad(reset_pad), .core_rail_ok(core_ok), .battery_rail_ok(bat_ok),
        .core_below_floor(floor), .battery_low(bat_low), .rail_low(rail_low),
        .watchdog_expired(wd), .cpu_reset_request(cpu), .wake_from_sleep(wake),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .por_reset(por_reset),
        .hw_reset(hw_reset), .soft_reboot_bit(soft_reboot_bit), .discharge_on(dis_on),
        .regulator_hold_off(hold_off), .core_threshold_sel(thr_sel), .dcdc_irq(dcdc_irq));

    rdc_pad_source #(.HOLD(4 * N + 10)) pad_src (.clk(clk), .start(pad_go),
        .short_hold(pad_short), .reset_pad(reset_pad));

    // Free-running 100 MHz clock
    initial
    begin
        forever #5 clk = ~clk;
    end

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        @(negedge clk);
        `CHK("rdata", e, rdata)
    endtask

    task automatic watch(input int k);
        {sp, sh, ss} = 3'h0;
        repeat (k)
        begin
            @(negedge clk);
            {sp, sh, ss} = {sp, sh, ss} | {por_reset, hw_reset, soft_reboot_bit};
        end
    endtask

    task automatic wait_idle();
        n = 0;
        while ((por_reset | hw_reset | soft_reboot_bit) !== 1'h0 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        `CHK("reset_release", 1'h1, n < 300)
    endtask

    // Waits for a discharge pattern, then counts how long it stands
    task automatic seg(input logic [2:0] v);
        n = 0;
        while (dis_on !== v && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        ho = hold_off;
        n = 0;
        while (dis_on === v && n < 200)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Guard against a hung sequencer
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        print_verdict();
    end

    initial
    begin
        repeat (12) @(posedge clk);
        `CHK("rst_levels", 3'h7, {por_reset, hw_reset, soft_reboot_bit})
        rst <= 1'h0;
        watch(20);
        `CHK("por_core_low", 1'h1, por_reset)
        @(posedge clk);
        core_ok <= 1'h1;
        wait_idle();
        `CHK("thr_sel", 2'h2, thr_sel)
        chk_reg(RDC_BOD_CTRL2_OFS, 32'h228);
        chk_reg(RDC_DIS_CFG_OFS, 32'h0);
        wr_reg(8'h40, 32'hFFFF);
        chk_reg(8'h40, 32'h0);
        foreach (rows[i])
        begin
            wr_reg(RDC_PWR_CTRL_OFS, rows[i].pre);
            @(posedge clk);
            {wd, cpu, wake} <= rows[i].src;
            addr <= rows[i].a;
            wdata <= rows[i].d;
            wr <= (rows[i].a != 8'hFF);
            @(posedge clk);
            {wd, cpu, wake, wr} <= 4'h0;
            watch(4);
            `CHK("hw_reset", rows[i].hw, sh)
            `CHK("soft_reboot_bit", rows[i].sw, ss)
            wait_idle();
        end
        // Pad-started discharge of rails one_four and one_eight_periph
        wr_reg(RDC_DIS_CFG_OFS, 32'h5);
        wr_reg(RDC_BOD_CTRL2_OFS, 32'h0);
        @(posedge clk);
        pad_go <= 1'h1;
        @(posedge clk);
        pad_go <= 1'h0;
        seg(3'h1);
        `CHK("dis_14", N, n)
        `CHK("hold_off", 3'h5, ho)
        `CHK("skip_18", 3'h4, dis_on)
        seg(3'h4);
        `CHK("dis_18p", N, n)
        `CHK("settle", 4'h1, {hold_off, hw_reset})
        wait_idle();
        chk_reg(RDC_DIS_CFG_OFS, 32'h5);
        chk_reg(RDC_BOD_CTRL2_OFS, 32'h228);
        // A pad blip still runs the whole sequence under reset
        @(posedge clk);
        {pad_go, pad_short} <= 2'h3;
        @(posedge clk);
        {pad_go, pad_short} <= 2'h0;
        repeat (N + 6) @(negedge clk);
        `CHK("blip_hold", 4'h9, {dis_on, hw_reset})
        wait_idle();
        wr_reg(RDC_DIS_TRIG_OFS, 32'h7);
        seg(3'h1);
        `CHK("sw_14", N, n)
        `CHK("sw_order", 3'h2, dis_on)
        `CHK("sw_no_hw", 1'h0, hw_reset)
        seg(3'h2);
        `CHK("sw_18", N, n)
        seg(3'h4);
        `CHK("sw_18p", N, n)
        // Brownout escalation, its enable, the hard floor and the battery warning
        @(posedge clk);
        rail_low <= 5'h08;
        watch(8);
        `CHK("bod_por", 1'h1, sp)
        @(posedge clk);
        rail_low <= 5'h00;
        wait_idle();
        chk_reg(RDC_DIS_CFG_OFS, 32'h0);
        wr_reg(RDC_BOD_CTRL2_OFS, 32'h208);
        @(posedge clk);
        rail_low <= 5'h08;
        watch(8);
        `CHK("bod_masked", 1'h0, sp)
        chk_reg(RDC_BOD_STAT_OFS, 32'h8);
        @(posedge clk);
        rail_low <= 5'h00;
        floor <= 1'h1;
        watch(8);
        `CHK("floor_por", 1'h1, sp)
        @(posedge clk);
        floor <= 1'h0;
        wait_idle();
        wr_reg(RDC_BOD_STAT_OFS, 32'h1F);
        chk_reg(RDC_BOD_STAT_OFS, 32'h0);
        // Battery rail under its minimum holds power-on reset
        @(posedge clk);
        bat_ok <= 1'h0;
        watch(8);
        `CHK("bat_por", 1'h1, por_reset)
        @(posedge clk);
        bat_ok <= 1'h1;
        wait_idle();
        @(posedge clk);
        bat_low <= 1'h1;
        watch(8);
        `CHK("bat_irq", 2'h1, {sp, dcdc_irq})
        print_verdict();
    end
endmodule
